// File: logic/spi_port.v
// Serial peripheral port that works as master or slave on a four-wire link, with APB registers.
// Assumes one 20 MHz clock, link pins that arrive asynchronously, and pads resolved outside.
//
// Contract
// - Master with select pin as output: pin is plain output, no link effect.
// - Select low while master with input pin: drop master bit, become slave.
// - That forced drop also sets the transfer-complete flag.
// - Four formats by clock polarity and phase; phase picks the sample edge.
// - Data changes on one clock edge and is captured on the other.
// - Master clock is system clock over 4, 16, 64, 128; double speed halves.
// - With double speed the shortest clock period is two system clocks.
// - Transfer-complete flag in status bit 7 sets when a transfer ends.
// - Interrupt request when flag set, enable bit set and global enable.
// - Flag clears when the processor takes the matching vector.
// - Flag clears on status read with flag set, then data access.
// - Collision flag, status bit 6, sets on data write during a transfer.
// - Status read with collision set then data access clears both flags.
// - Status bits 5 to 1 always read zero.
// - Status bit 0 holds the writable double-speed control.
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_regs.vh"

module spi_port (
	input wire SYS_CLK, // System clock, 20 MHz.
	input wire RST, // Synchronous reset, active high.
	input wire PSEL, // APB select.
	input wire PENABLE, // APB access phase.
	input wire PWRITE, // APB write when high.
	input wire [7:0] PADDR, // APB byte address.
	input wire [31:0] PWDATA, // APB write data.
	output reg [31:0] PRDATA, // APB read data.
	output wire PREADY, // APB ready.
	output wire PSLVERR, // APB error on unmapped address.
	input wire GLOBAL_IRQ_EN, // Processor global interrupt enable.
	input wire VECTOR_ACK, // Pulse when the port vector is taken.
	output wire XFER_IRQ, // Transfer interrupt request.
	output wire IRQ, // Masked sticky event interrupt.
	input wire SCK_I, // Serial clock pad input.
	output reg SCK_O, // Serial clock pad output.
	output wire SCK_OE, // Serial clock output enable.
	input wire MOSI_I, // Master-out pad input.
	output wire MOSI_O, // Master-out pad output.
	output wire MOSI_OE, // Master-out output enable.
	input wire MISO_I, // Master-in pad input.
	output wire MISO_O, // Master-in pad output.
	output wire MISO_OE, // Master-in output enable.
	input wire SS_N_I, // Slave select pad input, active low.
	output wire SS_N_O, // Slave select pad output.
	output wire SS_N_OE // Slave select output enable.
);

	// ----------------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------------
	reg [7:0] ctrl_q;
	reg done_q;
	reg write_collision_flag_q;
	reg dbl_q;
	reg [1:0] pin_q;
	reg [2:0] irq_stat_q;
	reg [2:0] irq_mask_q;
	reg arm_done_q;
	reg arm_write_collision_flag_q;
	reg [7:0] rdbuf_q;
	reg [7:0] tx_q;
	reg [7:0] rx_q;
	reg [2:0] bit_cnt_q;
	reg [3:0] edge_q;
	reg [5:0] div_q;
	reg active_q;
	// Two-stage pipelines that line the master's capture up with the synchronised data bit.
	reg [1:0] cap_q;
	reg [1:0] last_q;
	reg [1:0] end_q;
	reg sck_s1_q, sck_s2_q, sck_s3_q;
	reg mosi_s1_q, mosi_s2_q;
	reg miso_s1_q, miso_s2_q;
	reg ss_s1_q, ss_s2_q;

	// ----------------------------------------------------------------------
	// Decoded control
	// ----------------------------------------------------------------------
	wire enable = ctrl_q[`SPI_CTRL_ENABLE];
	wire master = ctrl_q[`SPI_CTRL_MASTER];
	wire cpol = ctrl_q[`SPI_CTRL_CPOL];
	wire cpha = ctrl_q[`SPI_CTRL_CPHA];
	wire ss_dir = pin_q[`SPI_PIN_SS_DIR];
	wire [2:0] rate = {dbl_q, ctrl_q[`SPI_CTRL_RATE_HI], ctrl_q[`SPI_CTRL_RATE_LO]};
	reg [5:0] half_m1;

	always @* begin
		case (rate)
			3'h0: half_m1 = `SPI_HALF_DIV4;
			3'h1: half_m1 = `SPI_HALF_DIV16;
			3'h2: half_m1 = `SPI_HALF_DIV64;
			3'h3: half_m1 = `SPI_HALF_DIV128;
			3'h4: half_m1 = `SPI_HALF_DIV2;
			3'h5: half_m1 = `SPI_HALF_DIV8;
			3'h6: half_m1 = `SPI_HALF_DIV32;
			default: half_m1 = `SPI_HALF_DIV64;
		endcase
	end

	// ----------------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------------
	wire access = PSEL & PENABLE;
	wire wr = access & PWRITE;
	wire rd = access & ~PWRITE;
	wire hit_ctrl = (PADDR == `SPI_ADDR_CTRL);
	wire hit_stat = (PADDR == `SPI_ADDR_STAT);
	wire hit_data = (PADDR == `SPI_ADDR_DATA);
	wire hit_pin = (PADDR == `SPI_ADDR_PIN);
	wire hit_istat = (PADDR == `SPI_ADDR_IRQ_STAT);
	wire hit_imask = (PADDR == `SPI_ADDR_IRQ_MASK);
	wire mapped = hit_ctrl | hit_stat | hit_data | hit_pin | hit_istat | hit_imask;

	// The slave answers in the access phase without wait states.
	assign PREADY = 1'b1;
	assign PSLVERR = access & ~mapped;

	wire [7:0] stat_view = {done_q, write_collision_flag_q, 5'h00, dbl_q};
	reg [7:0] rd_mux;

	always @* begin
		rd_mux = 8'h00;
		if (hit_ctrl) begin
			rd_mux = ctrl_q;
		end else if (hit_stat) begin
			rd_mux = stat_view;
		end else if (hit_data) begin
			rd_mux = rdbuf_q;
		end else if (hit_pin) begin
			rd_mux = {6'h00, pin_q};
		end else if (hit_istat) begin
			rd_mux = {5'h00, irq_stat_q};
		end else if (hit_imask) begin
			rd_mux = {5'h00, irq_mask_q};
		end
	end

	// Read data is captured in the setup cycle so that PRDATA comes from a flop.
	always @(posedge SYS_CLK) begin
		if (RST) begin
			PRDATA <= 32'h00000000;
		end else if (PSEL & ~PENABLE & ~PWRITE) begin
			PRDATA <= {24'h000000, rd_mux};
		end
	end

	// ----------------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------------
	always @(posedge SYS_CLK) begin
		if (RST) begin
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_s3_q <= 1'b0;
			mosi_s1_q <= 1'b0;
			mosi_s2_q <= 1'b0;
			miso_s1_q <= 1'b0;
			miso_s2_q <= 1'b0;
			ss_s1_q <= 1'b1;
			ss_s2_q <= 1'b1;
		end else begin
			sck_s1_q <= SCK_I;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			mosi_s1_q <= MOSI_I;
			mosi_s2_q <= mosi_s1_q;
			miso_s1_q <= MISO_I;
			miso_s2_q <= miso_s1_q;
			ss_s1_q <= SS_N_I;
			ss_s2_q <= ss_s1_q;
		end
	end

	// ----------------------------------------------------------------------
	// Link events
	// ----------------------------------------------------------------------
	// select held low while master with select pin as input
	wire fault = enable & master & ~ss_dir & ~ss_s2_q;
	wire selected = enable & ~master & ~ss_s2_q;
	wire tick = active_q & (div_q == half_m1);
	wire sck_chg = sck_s2_q ^ sck_s3_q;

	wire lead_sl = selected & sck_chg & (sck_s2_q != cpol);
	wire trail_sl = selected & sck_chg & (sck_s2_q == cpol);
	wire lead = master ? (tick & ~edge_q[0]) : lead_sl;
	wire trail = master ? (tick & edge_q[0]) : trail_sl;

	wire sample_ev = cpha ? trail : lead;
	wire setup_ev = (cpha ? lead : trail) & (bit_cnt_q != 3'h0);
	wire in_bit = master ? miso_s2_q : mosi_s2_q;
	// The returning bit spends two clocks in the pin synchroniser, so the master captures
	// it two clocks after its own sample edge. Without this the fast rates lose a bit.
	wire cap_ev = master ? cap_q[1] : sample_ev;
	wire last_m = sample_ev & (bit_cnt_q == `SPI_LAST_BIT);
	wire byte_in = master ? last_q[1] : last_m;
	wire master_end = tick & (edge_q == `SPI_LAST_EDGE);

	// completion event
	// The master reports completion only once the delayed capture has filled the buffer.
	wire xfer_done = master ? end_q[1] : byte_in;
	wire busy = master ? (active_q | (|end_q)) : (selected & (bit_cnt_q != 3'h0));
	wire data_wr = wr & hit_data;
	wire data_acc = access & hit_data;

	wire collide = data_wr & busy;
	wire start = data_wr & ~busy & enable & master & ~fault;

	// ----------------------------------------------------------------------
	// Control, status and interrupt registers
	// ----------------------------------------------------------------------
	// fault also completes
	wire done_set = xfer_done | fault;
	wire done_clr = VECTOR_ACK | (data_acc & (arm_done_q | arm_write_collision_flag_q));
	wire write_collision_flag_clr = data_acc & arm_write_collision_flag_q;
	wire [2:0] irq_set = {fault, collide, done_set};

	always @(posedge SYS_CLK) begin
		if (RST) begin
			ctrl_q <= `SPI_CTRL_RESET;
			pin_q <= `SPI_PIN_RESET;
			dbl_q <= 1'b0;
			done_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			arm_done_q <= 1'b0;
			arm_write_collision_flag_q <= 1'b0;
			irq_stat_q <= 3'h0;
			irq_mask_q <= 3'h0;
		end else begin
			if (wr & hit_ctrl) begin
				ctrl_q <= PWDATA[7:0];
			end
			if (fault) begin
				ctrl_q[`SPI_CTRL_MASTER] <= 1'b0;
			end
			if (wr & hit_pin) begin
				pin_q <= PWDATA[1:0];
			end
			if (wr & hit_stat) begin
				dbl_q <= PWDATA[`SPI_STAT_DBL];
			end
			if (wr & hit_imask) begin
				irq_mask_q <= PWDATA[2:0];
			end
			// Set wins over a same-cycle write-one clear.
			irq_stat_q <= (irq_stat_q & ~((wr & hit_istat) ? PWDATA[2:0] : 3'h0)) | irq_set;
			if (done_set) begin
				done_q <= 1'b1;
			end else if (done_clr) begin
				done_q <= 1'b0;
			end
			if (collide) begin
				write_collision_flag_q <= 1'b1;
			end else if (write_collision_flag_clr) begin
				write_collision_flag_q <= 1'b0;
			end
			// A data access consumes the arming left by an earlier status read.
			if (rd & hit_stat) begin
				arm_done_q <= done_q;
				arm_write_collision_flag_q <= write_collision_flag_q;
			end else if (data_acc) begin
				arm_done_q <= 1'b0;
				arm_write_collision_flag_q <= 1'b0;
			end
		end
	end

	assign XFER_IRQ = done_q & ctrl_q[`SPI_CTRL_IRQ_EN] & GLOBAL_IRQ_EN;
	assign IRQ = |(irq_stat_q & irq_mask_q);

	// ----------------------------------------------------------------------
	// Shift engine
	// ----------------------------------------------------------------------
	always @(posedge SYS_CLK) begin
		if (RST) begin
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			rdbuf_q <= 8'h00;
			bit_cnt_q <= 3'h0;
			edge_q <= 4'h0;
			div_q <= 6'h00;
			active_q <= 1'b0;
			SCK_O <= 1'b0;
			cap_q <= 2'h0;
			last_q <= 2'h0;
			end_q <= 2'h0;
		end else begin
			cap_q <= {cap_q[0], sample_ev & master};
			last_q <= {last_q[0], last_m & master};
			end_q <= {end_q[0], master_end};
			if (start) begin
				active_q <= 1'b1;
				edge_q <= 4'h0;
				div_q <= 6'h00;
				bit_cnt_q <= 3'h0;
			end else if (fault | ~enable | ~master) begin
				active_q <= 1'b0;
			end else if (tick) begin
				div_q <= 6'h00;
				edge_q <= edge_q + 4'h1;
				SCK_O <= ~SCK_O;
				if (master_end) begin
					active_q <= 1'b0;
				end
			end else if (active_q) begin
				div_q <= div_q + 6'h01;
			end
			if (~active_q) begin
				SCK_O <= cpol;
			end
			if (data_wr & ~busy) begin
				tx_q <= PWDATA[7:0];
			end else if (setup_ev) begin
				tx_q <= {tx_q[6:0], 1'b0};
			end
			if (cap_ev) begin
				rx_q <= {rx_q[6:0], in_bit};
			end
			// The bit count follows the undelayed edge so that the shift gating stays exact.
			if (sample_ev) begin
				bit_cnt_q <= bit_cnt_q + 3'h1;
			end else if (~master & ~selected) begin
				bit_cnt_q <= 3'h0;
			end
			if (byte_in) begin
				rdbuf_q <= {rx_q[6:0], in_bit};
			end
		end
	end

	// ----------------------------------------------------------------------
	// Pad drive
	// ----------------------------------------------------------------------
	// slave releases clock and data out
	assign SCK_OE = enable & master;
	assign MOSI_OE = enable & master;
	assign MOSI_O = tx_q[7];
	assign MISO_OE = selected;
	assign MISO_O = tx_q[7];
	assign SS_N_OE = ss_dir;
	assign SS_N_O = pin_q[`SPI_PIN_SS_VAL];

endmodule // spi_port
`default_nettype wire

// File: pkg/spi_port_regs.vh
// Register map, field positions, reset values and clock-rate constants of the serial port.
// Assumes byte addressing on a 32-bit APB bus with one register per aligned word.
`ifndef SPI_PORT_REGS_VH
`define SPI_PORT_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SPI_ADDR_CTRL 8'h00
`define SPI_ADDR_STAT 8'h04
`define SPI_ADDR_DATA 8'h08
`define SPI_ADDR_PIN 8'h0c
`define SPI_ADDR_IRQ_STAT 8'h10
`define SPI_ADDR_IRQ_MASK 8'h14

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define SPI_CTRL_IRQ_EN 7
`define SPI_CTRL_ENABLE 6
`define SPI_CTRL_MASTER 4
`define SPI_CTRL_CPOL 3
`define SPI_CTRL_CPHA 2
`define SPI_CTRL_RATE_HI 1
`define SPI_CTRL_RATE_LO 0
`define SPI_CTRL_RESET 8'h00

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define SPI_STAT_DONE 7
`define SPI_STAT_WRITE_COLLISION_FLAG 6
`define SPI_STAT_DBL 0

// ----------------------------------------------------------------------
// Pin control register fields
// ----------------------------------------------------------------------
`define SPI_PIN_SS_DIR 0
`define SPI_PIN_SS_VAL 1
`define SPI_PIN_RESET 2'h2

// ----------------------------------------------------------------------
// Interrupt status and mask bits
// ----------------------------------------------------------------------
`define SPI_IRQ_DONE 0
`define SPI_IRQ_WRITE_COLLISION_FLAG 1
`define SPI_IRQ_FAULT 2

// ----------------------------------------------------------------------
// SCK half period minus one, in system clocks, per rate code, then the last edge and last bit indices
// ----------------------------------------------------------------------
`define SPI_HALF_DIV4 6'h01
`define SPI_HALF_DIV16 6'h07
`define SPI_HALF_DIV64 6'h1f
`define SPI_HALF_DIV128 6'h3f
`define SPI_HALF_DIV2 6'h00
`define SPI_HALF_DIV8 6'h03
`define SPI_HALF_DIV32 6'h0f
`define SPI_LAST_EDGE 4'hf
`define SPI_LAST_BIT 3'h7

`endif

// File: test/spi_port_chk.sv
// Checker for the serial port: bus replies, pin enables, flags and faults.
// Assumes it is bound to spi_port and that every port shares SYS_CLK.
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_regs.vh"
module spi_port_chk (
	input wire SYS_CLK, // Clock.
	input wire RST, // Reset.
	input wire PSEL, // Select.
	input wire PENABLE, // Access.
	input wire PWRITE, // Write.
	input wire [7:0] PADDR, // Address.
	input wire [31:0] PRDATA, // Read data.
	input wire GLOBAL_IRQ_EN, // Global enable.
	input wire VECTOR_ACK, // Vector taken.
	input wire XFER_IRQ, // Done request.
	input wire SCK_O, // Clock out.
	input wire SCK_OE, // Clock enable.
	input wire MOSI_O, // Data out.
	input wire MOSI_OE, // Data enable.
	input wire MISO_OE, // Slave data enable.
	input wire SS_N_I, // Select in.
	input wire SS_N_OE // Select enable.
);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);
	wire acc;
	assign acc = PSEL && PENABLE;
	sequence s_fault;
		!SS_N_OE && !SS_N_I;
	endsequence
	sequence s_stat_done;
		acc && !PWRITE && PADDR == `SPI_ADDR_STAT && PRDATA[7];
	endsequence
	sequence s_data_acc;
		acc && PADDR == `SPI_ADDR_DATA;
	endsequence
	// Five cycles leave room for the two-flop select synchroniser.
	property p_fault_drop;
		s_fault [*5] |-> !SCK_OE && !MOSI_OE;
	endproperty
	a_fault_drop: assert property (p_fault_drop) else $error("master kept");
	property p_ss_out;
		SCK_OE && SS_N_OE && !PSEL |=> SCK_OE;
	endproperty
	a_ss_out: assert property (p_ss_out) else $error("select output hit master");
	property p_irq_gate;
		XFER_IRQ |-> GLOBAL_IRQ_EN;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request without enable");
	property p_vector;
		VECTOR_ACK |=> !XFER_IRQ;
	endproperty
	a_vector: assert property (p_vector) else $error("flag kept after vector");
	property p_flag_clear;
		s_stat_done ##[1:4] s_data_acc |=> !XFER_IRQ;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag kept");
	property p_oe_roles;
		MISO_OE |-> !SCK_OE && !MOSI_OE;
	endproperty
	a_oe_roles: assert property (p_oe_roles) else $error("slave drives clock");
	property p_mosi_hold;
		SCK_OE && $changed(MOSI_O) |-> $changed(SCK_O) || $past(acc);
	endproperty
	a_mosi_hold: assert property (p_mosi_hold) else $error("data moved off edge");
	property p_rsvd;
		acc && !PWRITE && PADDR == `SPI_ADDR_STAT |-> PRDATA[5:1] == 5'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
endmodule // spi_port_chk
bind spi_port spi_port_chk chk_i (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
	.GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .VECTOR_ACK(VECTOR_ACK), .XFER_IRQ(XFER_IRQ),
	.SCK_O(SCK_O), .SCK_OE(SCK_OE), .MOSI_O(MOSI_O), .MOSI_OE(MOSI_OE),
	.MISO_OE(MISO_OE), .SS_N_I(SS_N_I), .SS_N_OE(SS_N_OE));
`default_nettype wire

// File: test/spi_slave_model.sv
// Behavioural slave on the far side of the link.
// Assumes the bench sets the mode bits and the byte to send before select falls.
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
	input wire logic sck, // Link clock.
	input wire logic ss_n, // Select, active low.
	input wire logic mosi, // Data in.
	output logic miso, // Data out.
	input wire logic cpol, // Idle level.
	input wire logic cpha, // Sample phase.
	input wire logic [7:0] tx, // Byte to send.
	output logic [7:0] rx // Byte received.
);
	logic [8:0] sh;
	always @(negedge ss_n) sh = cpha ? {1'b0, tx} : {tx, 1'b0};
	always @(sck) begin
		if (!ss_n && sck == !(cpol ^ cpha))
			rx = {rx[6:0], mosi};
		else if (!ss_n)
			sh = {sh[7:0], 1'b0};
	end
	// Deselected, the line shows the inverse so a stale bit cannot pass.
	assign miso = ss_n ? ~sh[8] : sh[8];
endmodule // spi_slave_model
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the serial port: registers, transfers, faults, interrupts.
// Assumes spi_port with its bound checker and the behavioural slave.
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_regs.vh"
module tb_top;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic gie = 1'b0, vack = 1'b0, ss_drv = 1'b1, cpol = 1'b0, cpha = 1'b0, perr;
	logic [7:0] paddr = 8'h00, s_tx = 8'h00, s_rx;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, xirq, irq, sck_o, sck_oe, mosi_o, mosi_oe;
	logic miso_o, miso_oe, ss_o, ss_oe, s_miso;
	int n_mismatch = 0, samples_checked = 0, cyc = 0, half = 0;
	time t0 = 0;
	logic sck_drv = 1'b0, mosi_drv = 1'b0;
	wire sck_w = sck_oe ? sck_o : sck_drv;
	wire mosi_w = mosi_oe ? mosi_o : mosi_drv;
	wire miso_w = miso_oe ? miso_o : s_miso;
	wire ss_w = ss_oe ? ss_o : ss_drv;
	spi_port dut (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .GLOBAL_IRQ_EN(gie), .VECTOR_ACK(vack), .XFER_IRQ(xirq),
		.IRQ(irq), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_I(mosi_w),
		.MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o),
		.MISO_OE(miso_oe), .SS_N_I(ss_w), .SS_N_O(ss_o), .SS_N_OE(ss_oe));
	spi_slave_model slave (.sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .miso(s_miso),
		.cpol(cpol), .cpha(cpha), .tx(s_tx), .rx(s_rx));
	initial forever #25 clk = ~clk;
	always @(sck_o) if (sck_oe) begin
		half = int'(($time - t0) / 50);
		t0 = $time;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs();
		apb(0, `SPI_ADDR_PIN, 32'h0);
		chk(r, 32'h2);
		apb(1, `SPI_ADDR_STAT, 32'hff);
		apb(0, `SPI_ADDR_STAT, 32'h0);
		chk(r, 32'h1);
		apb(0, 8'h40, 32'h0);
		chk({r[30:0], perr}, 32'h1);
		$display("regs done");
	endtask
	task t_modes();
		int div;
		for (int i = 0; i < 8; i++) begin
			cpol = i[1];
			cpha = i[0];
			s_tx = 8'h5a ^ i[7:0];
			div = (i[1:0] == 0) ? 4 : (i[1:0] == 1) ? 16 : (i[1:0] == 2) ? 64 : 128;
			if (i[2])
				div = (i[1:0] == 3) ? 64 : div / 2;
			apb(1, `SPI_ADDR_STAT, {31'h0, i[2]});
			apb(1, `SPI_ADDR_PIN, 32'h3);
			apb(1, `SPI_ADDR_CTRL, {24'h0, 4'hd, i[1], i[0], i[1], i[0]});
			apb(1, `SPI_ADDR_PIN, 32'h1);
			apb(1, `SPI_ADDR_DATA, {24'h0, 8'hc3 ^ i[7:0]});
			do apb(0, `SPI_ADDR_STAT, 32'h0); while (r[7] !== 1'b1);
			chk(xirq, 1'b1);
			apb(0, `SPI_ADDR_DATA, 32'h0);
			chk(r, {24'h0, s_tx});
			chk(s_rx, 8'hc3 ^ i[7:0]);
			chk(half, div / 2);
			chk(sck_o, cpol);
			apb(0, `SPI_ADDR_STAT, 32'h0);
			chk(r, {31'h0, i[2]});
			apb(0, `SPI_ADDR_CTRL, 32'h0);
			chk(r[4], 1'b1);
		end
		$display("modes done");
	endtask
	task t_write_collision_flag();
		apb(1, `SPI_ADDR_PIN, 32'h3);
		apb(1, `SPI_ADDR_PIN, 32'h1);
		apb(1, `SPI_ADDR_DATA, 32'h11);
		apb(1, `SPI_ADDR_DATA, 32'h22);
		do apb(0, `SPI_ADDR_STAT, 32'h0); while (r[7] !== 1'b1);
		chk(r[7:6], 2'h3);
		chk(s_rx, 8'h11);
		apb(0, `SPI_ADDR_DATA, 32'h0);
		apb(0, `SPI_ADDR_STAT, 32'h0);
		chk(r[7:6], 2'h0);
		apb(1, `SPI_ADDR_DATA, 32'h33);
		while (xirq !== 1'b1) @(posedge clk);
		vack <= 1'b1;
		@(posedge clk);
		vack <= 1'b0;
		@(negedge clk);
		chk(xirq, 1'b0);
		apb(0, `SPI_ADDR_STAT, 32'h0);
		chk(r[7], 1'b0);
		$display("collision done");
	endtask
	task t_fault();
		apb(1, `SPI_ADDR_PIN, 32'h0);
		ss_drv <= 1'b0;
		repeat (6) @(posedge clk);
		chk({sck_oe, mosi_oe}, 2'h0);
		apb(0, `SPI_ADDR_CTRL, 32'h0);
		chk(r[4], 1'b0);
		apb(0, `SPI_ADDR_STAT, 32'h0);
		chk(r[7], 1'b1);
		apb(0, `SPI_ADDR_DATA, 32'h0);
		ss_drv <= 1'b1;
		apb(1, `SPI_ADDR_CTRL, 32'h50);
		@(negedge clk);
		chk(sck_oe, 1'b1);
		$display("fault done");
	endtask
	task t_irq();
		apb(0, `SPI_ADDR_IRQ_STAT, 32'h0);
		chk(r, 32'h7);
		chk(irq, 1'b0);
		apb(1, `SPI_ADDR_IRQ_MASK, 32'h4);
		@(negedge clk);
		chk(irq, 1'b1);
		apb(1, `SPI_ADDR_IRQ_STAT, 32'h7);
		@(negedge clk);
		chk(irq, 1'b0);
		$display("irq done");
	endtask
	task t_slave();
		logic [7:0] got;
		logic [7:0] pat;
		pat = 8'h3c;
		apb(1, `SPI_ADDR_CTRL, 32'h40);
		apb(1, `SPI_ADDR_DATA, 32'h96);
		ss_drv <= 1'b0;
		for (int b = 7; b >= 0; b--) begin
			mosi_drv <= pat[b];
			repeat (4) @(posedge clk);
			got[b] = miso_w;
			sck_drv <= 1'b1;
			repeat (4) @(posedge clk);
			sck_drv <= 1'b0;
		end
		repeat (6) @(posedge clk);
		ss_drv <= 1'b1;
		apb(0, `SPI_ADDR_STAT, 32'h0);
		chk(r[7], 1'b1);
		apb(0, `SPI_ADDR_DATA, 32'h0);
		chk(r, 32'h3c);
		chk(got, 8'h96);
		$display("slave done");
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		gie <= 1'b1;
		t_regs();
		t_modes();
		t_write_collision_flag();
		t_fault();
		t_irq();
		t_slave();
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
